/* design/lxio_ext_io.sv */
// contact-closure control input decoder and status outputs
`timescale 1ns/1ns
// What this block does
// - honour external inputs only while remote-select closed
// - high voltage follows its input level
// - fault alarm latched, cleared by clear input
// - halt closure stops repeated output sequence
// - aiming light follows its input
// - cavity shutter open while gate input closed
// - branch pick inputs select beam units
// - recipe number from weighted five inputs
// - end-of-shot output closed 40 ms per flash
// - fault status open until fault cleared
// - input-acceptable output mirrors remote select
// - ready when high voltage on and charged
module lxio_ext_io #(
  parameter int unsigned END_CYC = lxio_pkg::END_PULSE_CYC,
  parameter int unsigned DB_CYC = lxio_pkg::DEBOUNCE_CYC
) (
  input wire logic core_clk, // system clock, 10 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic clkEn, // freezes all state while low
  input wire logic remoteSelectIn, // remote_select_in, 1 = closed
  input wire logic highVoltageSwitchIn, // 1 = closed, hv wanted
  input wire logic faultClearIn, // 1 = closed
  input wire logic emitStartIn, // 1 = closed
  input wire logic emitHaltIn, // 1 = closed
  input wire logic aimLightIn, // 1 = closed
  input wire logic cavityGateIn, // 1 = closed
  input wire logic [lxio_pkg::BRANCH_N-1:0] branchPickIn, // 1 = closed
  input wire logic [lxio_pkg::RECIPE_W-1:0] recipeSelIn, // weight 1..16
  input wire logic [lxio_pkg::START_CNT_W-1:0] startMinCyc, // min hold
  input wire logic faultPresent, // internal fault condition level
  input wire logic capCharged, // storage capacitor full
  input wire logic flashDone, // one-cycle pulse per lamp flash
  input wire logic seqDone, // one-cycle pulse, sequence finished
  output logic highVoltageOn, // hv supply enable
  output logic aimLightOn, // guide light enable
  output logic shutterOpen, // cavity shutter open
  output logic [lxio_pkg::BRANCH_N-1:0] branchSel, // selected units
  output logic [lxio_pkg::RECIPE_W-1:0] recipeNumber, // active recipe
  output logic emitStart, // one-cycle start command
  output logic emitHalt, // one-cycle halt command
  output logic seqActive, // output sequence running
  output logic faultAlarm, // latched alarm
  output logic troubleOk, // status pin, 1 = closed (no fault)
  output logic endOfShot, // status pin, 40 ms pulse
  output logic inputAccept, // status pin, remote honoured
  output logic readyOut // status pin, hv on and charged
);
  localparam int unsigned IN_N = lxio_pkg::IN_N;
  localparam int unsigned EW = $clog2(END_CYC + 1);
  localparam int unsigned SW = lxio_pkg::START_CNT_W;
  localparam logic [EW-1:0] END_LOAD = EW'(END_CYC);

  typedef struct packed {
    logic hvOn;
    logic aim;
    logic shutter;
    logic [lxio_pkg::BRANCH_N-1:0] branch;
    logic [lxio_pkg::RECIPE_W-1:0] recipe;
    logic startPulse;
    logic haltPulse;
    logic seq;
    logic fault;
    logic okPin;
    logic endPin;
    logic accept;
    logic ready;
    logic [SW-1:0] startCnt;
    logic startUsed;
    logic haltPrev;
    logic [EW-1:0] endCnt;
  } lxio_state_t;

  lxio_state_t q;
  lxio_state_t d;
  logic [IN_N-1:0] rawIn;
  logic [IN_N-1:0] cleanIn;

  // --------------------------------------------------------------
  // input conditioning
  // --------------------------------------------------------------
  // all contact inputs pass one shared filter bank
  always_comb begin
    rawIn = '0;
    rawIn[lxio_pkg::IDX_REMOTE] = remoteSelectIn;
    rawIn[lxio_pkg::IDX_HV] = highVoltageSwitchIn;
    rawIn[lxio_pkg::IDX_CLEAR] = faultClearIn;
    rawIn[lxio_pkg::IDX_START] = emitStartIn;
    rawIn[lxio_pkg::IDX_HALT] = emitHaltIn;
    rawIn[lxio_pkg::IDX_AIM] = aimLightIn;
    rawIn[lxio_pkg::IDX_GATE] = cavityGateIn;
    rawIn[lxio_pkg::IDX_BRANCH +: lxio_pkg::BRANCH_N] = branchPickIn;
    rawIn[lxio_pkg::IDX_RECIPE +: lxio_pkg::RECIPE_W] = recipeSelIn;
  end

  lxio_debounce #(
    .WIDTH(IN_N),
    .DB_CYC(DB_CYC)
  ) u_filter (
    .core_clk(core_clk),
    .srst(srst),
    .clkEn(clkEn),
    .rawIn(rawIn),
    .cleanOut(cleanIn)
  );

  // --------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------
  // one gate for the hv, clear, start, halt, aim and gate contacts: a closure counts only under remote
  // select, so an open selector can never leave a level stuck on
  function automatic logic honour(input logic remote, input logic lvl);
    return remote & lvl;
  endfunction

  always_comb begin
    logic remote;
    logic startLvl;
    logic haltLvl;
    logic startOk;
    remote = cleanIn[lxio_pkg::IDX_REMOTE];
    startLvl = honour(remote, cleanIn[lxio_pkg::IDX_START]);
    haltLvl = honour(remote, cleanIn[lxio_pkg::IDX_HALT]);
    startOk = 1'b0;
    d = q;
    d.startPulse = 1'b0;
    d.haltPulse = 1'b0;

    // levels are forced safe while the remote select is open
    d.hvOn = honour(remote, cleanIn[lxio_pkg::IDX_HV]);
    d.aim = honour(remote, cleanIn[lxio_pkg::IDX_AIM]);
    d.shutter = honour(remote, cleanIn[lxio_pkg::IDX_GATE]);
    d.branch = remote ?
      cleanIn[lxio_pkg::IDX_BRANCH +: lxio_pkg::BRANCH_N] : '0;
    d.accept = remote;
    d.ready = q.hvOn & capCharged;

    // start needs a closure held for the configured minimum,
    // and fires once per closure so a stuck contact cannot repeat
    if (!startLvl) begin
      d.startCnt = '0;
      d.startUsed = 1'b0;
    end else if (!q.startUsed) begin
      if (q.startCnt + SW'(1) >= startMinCyc) begin
        startOk = ~q.fault & ~q.seq & ~faultPresent; // new fault blocks
        d.startUsed = 1'b1;
      end else begin
        d.startCnt = q.startCnt + SW'(1);
      end
    end
    if (startOk) begin
      d.startPulse = 1'b1;
      d.seq = 1'b1;
      // weights 1,2,4,8,16 map to bit positions 0..4
      d.recipe =
        cleanIn[lxio_pkg::IDX_RECIPE +: lxio_pkg::RECIPE_W];
    end

    // halt acts on the filtered rising edge; the filter is shorter
    // than the minimum closure so every legal closure is caught
    d.haltPrev = haltLvl;
    if (haltLvl && !q.haltPrev && q.seq) begin
      d.haltPulse = 1'b1;
      d.seq = 1'b0;
    end else if (seqDone && !startOk) begin
      d.seq = 1'b0; // a start in the same cycle wins
    end

    // clear only after the cause is gone; a new fault wins
    if (faultPresent) begin
      d.fault = 1'b1;
    end else if (honour(remote, cleanIn[lxio_pkg::IDX_CLEAR])) begin
      d.fault = 1'b0;
    end
    if (d.fault) begin
      d.seq = 1'b0; // a fault ends any running sequence
    end
    d.okPin = ~d.fault;

    // fixed-width end pulse, a new flash restarts it
    if (flashDone) begin
      d.endCnt = END_LOAD;
    end else if (q.endCnt != '0) begin
      d.endCnt = q.endCnt - EW'(1);
    end
    d.endPin = (d.endCnt != '0);
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
      q.fault <= lxio_pkg::RST_FAULT;
      q.okPin <= lxio_pkg::RST_TROUBLE_OK;
    end else if (clkEn) begin
      q <= d;
    end
  end

  // --------------------------------------------------------------
  // outputs, each straight from the state register
  // --------------------------------------------------------------
  assign highVoltageOn = q.hvOn;
  assign aimLightOn = q.aim;
  assign shutterOpen = q.shutter;
  assign branchSel = q.branch;
  assign recipeNumber = q.recipe;
  assign emitStart = q.startPulse;
  assign emitHalt = q.haltPulse;
  assign seqActive = q.seq;
  assign faultAlarm = q.fault;
  assign troubleOk = q.okPin;
  assign endOfShot = q.endPin;
  assign inputAccept = q.accept;
  assign readyOut = q.ready;
endmodule // lxio_ext_io

/* design/lxio_pkg.sv */
// constants shared by the external contact-input decoder
package lxio_pkg;
  // --------------------------------------------------------------
  // clock and timing
  // --------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned DEBOUNCE_US = 100;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned HALT_MIN_MS = 1;
  localparam int unsigned HALT_MIN_CYC = HALT_MIN_MS * (CLK_HZ / 1_000);
  localparam int unsigned END_PULSE_MS = 40;
  localparam int unsigned END_PULSE_CYC = END_PULSE_MS * (CLK_HZ / 1_000);
  localparam int unsigned START_CNT_W = 20;

  // --------------------------------------------------------------
  // widths and input vector layout
  // --------------------------------------------------------------
  localparam int unsigned RECIPE_W = 5;
  localparam int unsigned BRANCH_N = 4;
  localparam int unsigned IDX_REMOTE = 0;
  localparam int unsigned IDX_HV = 1;
  localparam int unsigned IDX_CLEAR = 2;
  localparam int unsigned IDX_START = 3;
  localparam int unsigned IDX_HALT = 4;
  localparam int unsigned IDX_AIM = 5;
  localparam int unsigned IDX_GATE = 6;
  localparam int unsigned IDX_BRANCH = 7;
  localparam int unsigned IDX_RECIPE = IDX_BRANCH + BRANCH_N;
  localparam int unsigned IN_N = IDX_RECIPE + RECIPE_W;

  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic RST_FAULT = 1'b0;
  localparam logic RST_TROUBLE_OK = 1'b1;
endpackage

/* design/lxio_debounce.sv */
// three-flop synchroniser and debounce filter for contact inputs
`timescale 1ns/1ns
module lxio_debounce #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DB_CYC = lxio_pkg::DEBOUNCE_CYC
) (
  input wire logic core_clk, // system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic clkEn, // freezes all state while low
  input wire logic [WIDTH-1:0] rawIn, // asynchronous contact levels
  output logic [WIDTH-1:0] cleanOut // filtered levels, registered
);
  localparam int unsigned CW = $clog2(DB_CYC + 1);
  localparam logic [CW-1:0] DB_LAST = CW'(DB_CYC - 1);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0][CW-1:0] cnt;
  } lxio_db_t;

  lxio_db_t q;
  lxio_db_t d;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // s1 feeds only s2; a change counts once s2 and s3 agree
  always_comb begin
    d = q;
    d.s1 = rawIn;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (q.s2[i] != q.s3[i] || q.s3[i] == q.stable[i]) begin
        d.cnt[i] = '0; // bounce restarts the wait
      end else if (q.cnt[i] == DB_LAST) begin
        d.stable[i] = q.s3[i];
        d.cnt[i] = '0;
      end else begin
        d.cnt[i] = q.cnt[i] + CW'(1);
      end
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign cleanOut = q.stable;
endmodule // lxio_debounce

/* sim/lxio_ext_io_checker.sv */
// assertion checker for the contact input decoder
`timescale 1ns/1ns
module lxio_ext_io_checker #(
  parameter int unsigned END_CYC = lxio_pkg::END_PULSE_CYC
) (
  input wire logic core_clk, // clock
  input wire logic srst, // reset
  input wire logic clkEn, // run
  input wire logic faultPresent, // fault level
  input wire logic flashDone, // flash pulse
  input wire logic capCharged, // charged
  input wire logic highVoltageOn, // hv
  input wire logic aimLightOn, // aim
  input wire logic shutterOpen, // shutter
  input wire logic emitStart, // start
  input wire logic emitHalt, // halt
  input wire logic seqActive, // running
  input wire logic [lxio_pkg::RECIPE_W-1:0] recipeNumber, // recipe
  input wire logic faultAlarm, // alarm
  input wire logic troubleOk, // trouble pin
  input wire logic endOfShot, // end pin
  input wire logic inputAccept, // accept pin
  input wire logic readyOut // ready pin
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // ------------------------------------------------------------
  // end pulse width
  // ------------------------------------------------------------
  // a reload restarts the count, so extended pulses pass too
  int hiCnt_q;
  always_ff @(posedge core_clk) begin
    if (srst || (flashDone && clkEn))
      hiCnt_q <= 0;
    else if (endOfShot && clkEn)
      hiCnt_q <= hiCnt_q + 1;
  end
  a_end_width: assert property (
    $fell(endOfShot) |-> hiCnt_q == END_CYC)
    else $error("end pulse width wrong");
  a_fault_sets: assert property (faultPresent && clkEn |=> faultAlarm)
    else $error("alarm not raised");
  a_clear_cause: assert property (
    $fell(faultAlarm) |-> !$past(faultPresent))
    else $error("alarm cleared under fault");
  a_trouble_pin: assert property (troubleOk == !faultAlarm)
    else $error("trouble pin wrong");
  a_ready_pin: assert property ($past(clkEn) |->
    readyOut == $past(highVoltageOn && capCharged))
    else $error("ready pin wrong");
  a_remote_gate: assert property ((highVoltageOn || aimLightOn ||
    shutterOpen) |-> inputAccept)
    else $error("output on without remote");
  a_start_once: assert property (emitStart |->
    seqActive && !$past(seqActive) ##1 !emitStart)
    else $error("start pulse wrong");
  a_recipe_held: assert property ($changed(recipeNumber) |-> emitStart)
    else $error("recipe changed without start");
  a_halt_stops: assert property (emitHalt |->
    !seqActive && $past(seqActive))
    else $error("halt did not stop sequence");
endmodule // lxio_ext_io_checker

bind lxio_ext_io lxio_ext_io_checker #(.END_CYC(END_CYC)) chk (
  .core_clk, .srst, .clkEn, .faultPresent, .flashDone, .capCharged,
  .highVoltageOn, .aimLightOn, .shutterOpen, .emitStart, .emitHalt,
  .seqActive, .recipeNumber, .faultAlarm, .troubleOk, .endOfShot,
  .inputAccept, .readyOut
);

/* sim/lxio_plc_model.sv */
// controller model driving the contact-closure pins
`timescale 1ns/1ns
module lxio_plc_model #(
  parameter int unsigned HOLD_CYC = 24,
  parameter int unsigned GAP_CYC = 24
) (
  input wire logic core_clk, // system clock
  output logic [lxio_pkg::IN_N-1:0] pins // contacts, 1 = closed
);
  // ------------------------------------------------------------
  // contact actions, all at the falling edge
  // ------------------------------------------------------------
  initial pins = '0;
  // move the masked contacts to new levels
  task automatic setPins(input logic [15:0] m, input logic [15:0] v);
    @(negedge core_clk);
    pins = (pins & ~m) | (v & m);
  endtask
  // start held past filter and minimum, then open gap
  task automatic shot(input logic [lxio_pkg::RECIPE_W-1:0] r);
    setPins(16'hF808, {r, 11'h008});
    repeat (HOLD_CYC) @(negedge core_clk);
    pins[lxio_pkg::IDX_START] = 1'b0;
    repeat (GAP_CYC) @(negedge core_clk);
  endtask
  // halt closure kept well past the debounce time
  task automatic halt();
    setPins(16'h0010, 16'h0010);
    repeat (HOLD_CYC) @(negedge core_clk);
    pins[lxio_pkg::IDX_HALT] = 1'b0;
  endtask
endmodule // lxio_plc_model

/* sim/test_lxio_ext_io.sv */
// self-checking bench for the contact input decoder
`timescale 1ns/1ns
module test_lxio_ext_io;
  localparam int unsigned DB = 4;
  localparam int unsigned ENDC = 20;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic faultPresent = 1'b0;
  logic capCharged = 1'b0;
  logic flashDone = 1'b0;
  logic seqDone = 1'b0;
  logic clkEn = 1'b1;
  logic [15:0] pins;
  logic highVoltageOn, aimLightOn, shutterOpen, emitStart, emitHalt;
  logic seqActive, faultAlarm, troubleOk, endOfShot, inputAccept, readyOut;
  logic [3:0] branchSel;
  logic [4:0] recipeNumber;
  logic [4:0] expQ[$];
  logic [31:0] r;
  int err_total = 0;
  int n_compared = 0;
  int haltCnt = 0;
  always #50 core_clk = ~core_clk;
  lxio_plc_model plc (.core_clk(core_clk), .pins(pins));
  lxio_ext_io #(.END_CYC(ENDC), .DB_CYC(DB)) uut (
    .core_clk(core_clk), .srst(srst), .clkEn(clkEn),
    .remoteSelectIn(pins[0]), .highVoltageSwitchIn(pins[1]),
    .faultClearIn(pins[2]), .emitStartIn(pins[3]), .emitHaltIn(pins[4]),
    .aimLightIn(pins[5]), .cavityGateIn(pins[6]),
    .branchPickIn(pins[10:7]), .recipeSelIn(pins[15:11]),
    .startMinCyc(20'h00003), .faultPresent(faultPresent),
    .capCharged(capCharged), .flashDone(flashDone), .seqDone(seqDone),
    .highVoltageOn(highVoltageOn), .aimLightOn(aimLightOn),
    .shutterOpen(shutterOpen), .branchSel(branchSel),
    .recipeNumber(recipeNumber), .emitStart(emitStart),
    .emitHalt(emitHalt), .seqActive(seqActive), .faultAlarm(faultAlarm),
    .troubleOk(troubleOk), .endOfShot(endOfShot),
    .inputAccept(inputAccept), .readyOut(readyOut));
  // ------------------------------------------------------------
  // compare, verdict and settling helpers
  // ------------------------------------------------------------
  task automatic cmp(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // filter plus sync plus output stage, with margin
  task automatic settle();
    repeat (DB + 8) @(negedge core_clk);
  endtask
  // each start command takes the oldest noted recipe
  always @(posedge core_clk) begin
    #1;
    if (emitHalt === 1'b1)
      haltCnt++;
    if (emitStart === 1'b1) begin
      if (expQ.size() == 0)
        cmp("unexpected start", 8'h00, 8'h01);
      else
        cmp("recipe", expQ.pop_front(), recipeNumber);
    end
  end
  // hang guard
  initial begin
    repeat (30000) @(posedge core_clk);
    err_total++;
    finish_test();
  end
  // main sequence
  initial begin
    r = $urandom(32'h6709);
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    cmp("trouble reset", 8'h01, troubleOk);
    plc.setPins(16'h0062, 16'h0062);
    settle();
    cmp("ignored", 8'h00, {highVoltageOn, aimLightOn, shutterOpen});
    capCharged = 1'b1;
    plc.setPins(16'h0001, 16'h0001);
    settle();
    cmp("levels", 8'h0F, {highVoltageOn, aimLightOn, shutterOpen,
      inputAccept});
    cmp("ready", 8'h01, readyOut);
    plc.setPins(16'h0060, 16'h0000);
    settle();
    cmp("aim gate off", 8'h00, {aimLightOn, shutterOpen});
    // a low enable freezes filters and outputs alike
    clkEn = 1'b0;
    plc.setPins(16'h0020, 16'h0020);
    settle();
    cmp("frozen aim", 8'h00, aimLightOn);
    clkEn = 1'b1;
    settle();
    cmp("aim resumes", 8'h01, aimLightOn);
    // mid-run reset: held two edges, then inputs filter in again
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    cmp("rst lvl", 8'h00, {highVoltageOn, aimLightOn, inputAccept});
    cmp("rst trouble", 8'h01, troubleOk);
    srst = 1'b0;
    settle();
    cmp("lvl again", 8'h07, {highVoltageOn, aimLightOn, inputAccept});
    for (int i = 0; i < 5; i++) begin
      r = $urandom;
      plc.setPins(16'h0780, 16'(r << 7));
      settle();
      cmp("branch", {4'h0, r[3:0]}, branchSel);
      r[4:0] = (i == 0) ? 5'h1F : (i == 1) ? 5'h00 : r[8:4];
      expQ.push_back(r[4:0]);
      plc.shot(r[4:0]);
      seqDone = 1'b1;
      @(negedge core_clk);
      seqDone = 1'b0;
    end
    expQ.push_back(5'h0A);
    plc.shot(5'h0A);
    cmp("running", 8'h01, seqActive);
    plc.halt();
    settle();
    cmp("halted", 8'h00, seqActive);
    cmp("halt pulses", 8'h01, 8'(haltCnt));
    // a halt with nothing running is refused
    plc.halt();
    settle();
    cmp("idle halt", 8'h01, 8'(haltCnt));
    // clear held closed while the fault persists must not clear
    faultPresent = 1'b1;
    plc.setPins(16'h0004, 16'h0004);
    settle();
    cmp("alarm held", 8'h01, faultAlarm);
    cmp("trouble open", 8'h00, troubleOk);
    faultPresent = 1'b0;
    settle();
    cmp("alarm cleared", 8'h00, faultAlarm);
    plc.setPins(16'h0004, 16'h0000);
    flashDone = 1'b1;
    @(negedge core_clk);
    flashDone = 1'b0;
    cmp("end pin", 8'h01, endOfShot);
    repeat (ENDC - 1) @(negedge core_clk);
    cmp("end pin held", 8'h01, endOfShot);
    @(negedge core_clk);
    cmp("end pin done", 8'h00, endOfShot);
    plc.setPins(16'h0001, 16'h0000);
    plc.shot(5'h05);
    cmp("remote off", 8'h00, {highVoltageOn, inputAccept});
    cmp("notes left", 8'h00, 8'(expQ.size()));
    finish_test();
  end
endmodule // test_lxio_ext_io
